// ===== design/cscc_div_if.sv
// carrier between the clock selector and its main clock prescaler
`timescale 1ns/1ps
`default_nettype none
interface cscc_div_if;
    logic [2:0] div_sel;
    logic       run;
    logic       tick;

    modport ctrl (output div_sel, output run, input tick);
    modport div  (input div_sel, input run, output tick);
endinterface
`default_nettype wire

// ===== design/cscc_pkg.sv
// constants shared by the cpu clock select control design
package cscc_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_PROCESSOR_CLOCK_CONTROL = 32'hFFFFF828;
    localparam logic [31:0] ADDR_INTERNAL_OSC_MODE       = 32'hFFFFF830;
    localparam logic [31:0] ADDR_CPU_CLOCK_SOURCE_STATUS = 32'hFFFFF834;
    localparam logic [31:0] ADDR_PROTECTION_COMMAND      = 32'hFFFFF800;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_PROCESSOR_CLOCK_CONTROL = 8'h03;
    localparam logic [7:0] RST_INTERNAL_OSC_MODE       = 8'h00;
    localparam logic [7:0] RST_CPU_CLOCK_SOURCE_STATUS = 8'h00;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_SUB_FEEDBACK_RESISTOR_OFF  = 7;
    localparam int BIT_MAIN_OSC_STOP              = 6;
    localparam int BIT_MAIN_FEEDBACK_RESISTOR_OFF = 5;
    localparam int BIT_CPU_ON_SUBCLOCK_STATUS     = 4;
    localparam int BIT_SUBCLOCK_SELECT            = 3;
    localparam int BIT_INTERNAL_OSC_STOP          = 0;
    localparam int BIT_INTERNAL_OSC_FALLBACK_FLAG = 0;

    // ------------------------------------------------------------------
    // divider selector codes (bits 2..0 while subclock_select is 0)
    // ------------------------------------------------------------------
    localparam logic [2:0] DIV_SEL_MAX      = 3'h5;
    localparam int         DIV_CNT_W        = 5;

    typedef enum logic [1:0] {
        CSCC_REG_CTRL = 2'b00,
        CSCC_REG_MODE = 2'b01,
        CSCC_REG_STAT = 2'b10,
        CSCC_REG_NONE = 2'b11
    } cscc_reg_t;

endpackage

// ===== design/cscc_prescaler.sv
// main clock prescaler: one tick every 2**div_sel cycles
`timescale 1ns/1ps
`default_nettype none
module cscc_prescaler (
    input  wire logic clk_i,
    input  wire logic rst_i,
    cscc_div_if.div   div_port
);

    logic [cscc_pkg::DIV_CNT_W-1:0] cnt;
    logic [cscc_pkg::DIV_CNT_W-1:0] next_cnt;
    logic [cscc_pkg::DIV_CNT_W-1:0] limit;
    logic                           tick;
    logic                           next_tick;

    always_comb begin
        limit = cscc_pkg::DIV_CNT_W'((32'h1 << div_port.div_sel) - 32'h1);
        next_cnt  = cnt;
        next_tick = 1'b0;
        if (!div_port.run) begin
            // a stopped main clock yields no ticks and restarts cleanly
            next_cnt = '0;
        end else if (cnt >= limit) begin
            next_cnt  = '0;
            next_tick = 1'b1;
        end else begin
            next_cnt = cnt + cscc_pkg::DIV_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end

    assign div_port.tick = tick;

endmodule
`default_nettype wire

// ===== design/cscc_top.sv
// cpu clock select control: clock control registers on classic wishbone
//
// Notes on behaviour
// - control register writes need the protection sequence
// - control register resets to 03H
// - bit 6 requests main oscillator stop
// - main oscillator stops only after subclock switch
// - bit 7 turns subclock feedback resistor off
// - bit 5 turns main feedback resistor off
// - bit 4 read-only, shows cpu on subclock
// - selector decodes divide 1..32, 011x prohibited, 1xxx sub
// - switch to subclock within one subclock period
// - return to main within one subclock period
// - internal oscillator mode resets 00H, bit0 stops
// - fallback flag keeps internal oscillator running
// - status register read-only, flag shows internal clock
// - watchdog overflow in stabilization sets fallback flag
// - registers accept byte and single-bit accesses
// - main stop only on subclock; deep stop stops too
// - selected divided clock drives cpu and system clock
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cscc_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        we_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        sub_tick_i,
    input  wire logic        osc_stab_i,
    input  wire logic        wdt_overflow_i,
    input  wire logic        deep_stop_i,
    output logic             cpu_clk_en_o,
    output logic             cpu_on_subclock_o,
    output logic             main_osc_enable_o,
    output logic             main_feedback_resistor_off_o,
    output logic             sub_feedback_resistor_off_o,
    output logic             internal_osc_enable_o,
    output logic             internal_osc_fallback_o
);

    // ------------------------------------------------------------------
    // address decode, shared by the read and the write path
    // ------------------------------------------------------------------
    function automatic cscc_pkg::cscc_reg_t reg_decode(
        input logic [31:0] adr
    );
        cscc_pkg::cscc_reg_t r;
        r = cscc_pkg::CSCC_REG_NONE;
        if (adr == cscc_pkg::ADDR_PROCESSOR_CLOCK_CONTROL) begin
            r = cscc_pkg::CSCC_REG_CTRL;
        end else if (adr == cscc_pkg::ADDR_INTERNAL_OSC_MODE) begin
            r = cscc_pkg::CSCC_REG_MODE;
        end else if (adr == cscc_pkg::ADDR_CPU_CLOCK_SOURCE_STATUS) begin
            r = cscc_pkg::CSCC_REG_STAT;
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [3:0]  clock_sel;
    logic [2:0]  div_applied;
    logic        main_osc_stop;
    logic        main_fb_off;
    logic        sub_fb_off;
    logic        on_sub;
    logic        internal_osc_stop;
    logic        fallback;
    logic        armed;
    logic [3:0]  next_clock_sel;
    logic [2:0]  next_div_applied;
    logic        next_main_osc_stop;
    logic        next_main_fb_off;
    logic        next_sub_fb_off;
    logic        next_on_sub;
    logic        next_internal_osc_stop;
    logic        next_fallback;
    logic        next_armed;
    logic        next_ack;
    logic [31:0] next_dat;
    logic        next_cpu_clk_en;
    logic        next_main_osc_enable;
    logic        next_internal_osc_enable;

    logic                access;
    logic                wr_low;
    cscc_pkg::cscc_reg_t target;
    logic [7:0]          pcc_rd;
    logic [7:0]          wbyte;

    cscc_div_if div_bus ();

    cscc_prescaler u_prescaler (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .div_port (div_bus.div)
    );

    assign div_bus.div_sel = div_applied;
    assign div_bus.run     = main_osc_enable_o;

    // ------------------------------------------------------------------
    // bus slave: one request cycle, ack the following cycle
    // ------------------------------------------------------------------
    always_comb begin
        access = cyc_i && stb_i && !ack_o;
        // only byte lane 0 holds register bits; other lanes are ignored
        wr_low = access && we_i && sel_i[0];
        target = reg_decode(adr_i);
        wbyte  = dat_i[7:0];
        pcc_rd = '0;
        pcc_rd[cscc_pkg::BIT_SUB_FEEDBACK_RESISTOR_OFF]  = sub_fb_off;
        pcc_rd[cscc_pkg::BIT_MAIN_OSC_STOP]              = main_osc_stop;
        pcc_rd[cscc_pkg::BIT_MAIN_FEEDBACK_RESISTOR_OFF] = main_fb_off;
        pcc_rd[cscc_pkg::BIT_CPU_ON_SUBCLOCK_STATUS]     = on_sub;
        pcc_rd[3:0] = clock_sel;

        next_ack = access;
        next_dat = dat_o;
        if (access && !we_i) begin
            // single-bit reads are byte reads; unmapped reads give zero
            case (target)
                cscc_pkg::CSCC_REG_CTRL: begin
                    next_dat = {24'h000000, pcc_rd};
                end
                cscc_pkg::CSCC_REG_MODE: begin
                    next_dat = '0;
                    next_dat[cscc_pkg::BIT_INTERNAL_OSC_STOP] =
                        internal_osc_stop;
                end
                cscc_pkg::CSCC_REG_STAT: begin
                    next_dat = '0;
                    next_dat[cscc_pkg::BIT_INTERNAL_OSC_FALLBACK_FLAG] =
                        fallback;
                end
                default: begin
                    next_dat = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // protection sequence and register writes
    // ------------------------------------------------------------------
    always_comb begin
        next_armed             = armed;
        next_clock_sel         = clock_sel;
        next_div_applied       = div_applied;
        next_main_osc_stop     = main_osc_stop;
        next_main_fb_off       = main_fb_off;
        next_sub_fb_off        = sub_fb_off;
        next_internal_osc_stop = internal_osc_stop;

        // any access other than the protection write drops the key
        if (access) begin
            next_armed = wr_low &&
                (adr_i == cscc_pkg::ADDR_PROTECTION_COMMAND);
        end

        if (wr_low && target == cscc_pkg::CSCC_REG_CTRL && armed) begin
            next_sub_fb_off =
                wbyte[cscc_pkg::BIT_SUB_FEEDBACK_RESISTOR_OFF];
            next_main_osc_stop =
                wbyte[cscc_pkg::BIT_MAIN_OSC_STOP];
            next_main_fb_off =
                wbyte[cscc_pkg::BIT_MAIN_FEEDBACK_RESISTOR_OFF];
            next_clock_sel = wbyte[3:0];
            // prohibited 011x keeps the old ratio instead of guessing one
            if (!wbyte[cscc_pkg::BIT_SUBCLOCK_SELECT] &&
                wbyte[2:0] <= cscc_pkg::DIV_SEL_MAX) begin
                next_div_applied = wbyte[2:0];
            end
        end

        if (wr_low && target == cscc_pkg::CSCC_REG_MODE) begin
            next_internal_osc_stop =
                wbyte[cscc_pkg::BIT_INTERNAL_OSC_STOP];
        end
    end

    // ------------------------------------------------------------------
    // clock source switching and oscillator control
    // ------------------------------------------------------------------
    always_comb begin
        // the change lands on the next subclock edge, so never later
        // than one subclock period after the select bit moves
        next_on_sub = on_sub;
        if (sub_tick_i) begin
            next_on_sub = clock_sel[cscc_pkg::BIT_SUBCLOCK_SELECT];
        end

        // sticky until reset; nothing in software clears it
        next_fallback = fallback ||
            (osc_stab_i && wdt_overflow_i);

        // stop request is held off while the cpu still needs the main clock
        next_main_osc_enable = !(deep_stop_i ||
            (main_osc_stop && on_sub));

        next_internal_osc_enable = !internal_osc_stop || fallback;

        // divided main clock or subclock paces the cpu and system clock
        if (deep_stop_i) begin
            next_cpu_clk_en = 1'b0;
        end else if (on_sub) begin
            next_cpu_clk_en = sub_tick_i;
        end else begin
            next_cpu_clk_en = div_bus.tick;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clock_sel         <= cscc_pkg::RST_PROCESSOR_CLOCK_CONTROL[3:0];
            div_applied       <= cscc_pkg::RST_PROCESSOR_CLOCK_CONTROL[2:0];
            main_osc_stop     <= cscc_pkg::RST_PROCESSOR_CLOCK_CONTROL[
                                     cscc_pkg::BIT_MAIN_OSC_STOP];
            main_fb_off       <= cscc_pkg::RST_PROCESSOR_CLOCK_CONTROL[
                                     cscc_pkg::BIT_MAIN_FEEDBACK_RESISTOR_OFF];
            sub_fb_off        <= cscc_pkg::RST_PROCESSOR_CLOCK_CONTROL[
                                     cscc_pkg::BIT_SUB_FEEDBACK_RESISTOR_OFF];
            on_sub            <= cscc_pkg::RST_PROCESSOR_CLOCK_CONTROL[
                                     cscc_pkg::BIT_CPU_ON_SUBCLOCK_STATUS];
            internal_osc_stop <= cscc_pkg::RST_INTERNAL_OSC_MODE[
                                     cscc_pkg::BIT_INTERNAL_OSC_STOP];
            fallback          <= cscc_pkg::RST_CPU_CLOCK_SOURCE_STATUS[
                                     cscc_pkg::BIT_INTERNAL_OSC_FALLBACK_FLAG];
            armed             <= 1'b0;
            ack_o             <= 1'b0;
            dat_o             <= '0;
            cpu_clk_en_o      <= 1'b0;
            main_osc_enable_o <= 1'b1;
            internal_osc_enable_o <= 1'b1;
        end else begin
            clock_sel         <= next_clock_sel;
            div_applied       <= next_div_applied;
            main_osc_stop     <= next_main_osc_stop;
            main_fb_off       <= next_main_fb_off;
            sub_fb_off        <= next_sub_fb_off;
            on_sub            <= next_on_sub;
            internal_osc_stop <= next_internal_osc_stop;
            fallback          <= next_fallback;
            armed             <= next_armed;
            ack_o             <= next_ack;
            dat_o             <= next_dat;
            cpu_clk_en_o      <= next_cpu_clk_en;
            main_osc_enable_o <= next_main_osc_enable;
            internal_osc_enable_o <= next_internal_osc_enable;
        end
    end

    // mirrors are registered from the next-state values, so they track the state flops with no lag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_on_subclock_o            <= 1'b0;
            main_feedback_resistor_off_o <= 1'b0;
            sub_feedback_resistor_off_o  <= 1'b0;
            internal_osc_fallback_o      <= 1'b0;
        end else begin
            cpu_on_subclock_o            <= next_on_sub;
            main_feedback_resistor_off_o <= next_main_fb_off;
            sub_feedback_resistor_off_o  <= next_sub_fb_off;
            internal_osc_fallback_o      <= next_fallback;
        end
    end

endmodule
`default_nettype wire

// ===== verification/cscc_checker.sv
// assertion checker for the cpu clock select control block
`timescale 1ns/1ps
`default_nettype none
module cscc_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0]  sel_i,
    input wire logic        we_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        sub_tick_i,
    input wire logic        osc_stab_i,
    input wire logic        wdt_overflow_i,
    input wire logic        deep_stop_i,
    input wire logic        cpu_clk_en_o,
    input wire logic        cpu_on_subclock_o,
    input wire logic        main_osc_enable_o,
    input wire logic        main_feedback_resistor_off_o,
    input wire logic        sub_feedback_resistor_off_o,
    input wire logic        internal_osc_enable_o,
    input wire logic        internal_osc_fallback_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------------------------------
    // bus answer and clock source relations
    // ----------------------------------------------------------------
    property p_ack_lat; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    property p_ack_one; ack_o |=> !ack_o; endproperty
    property p_rd_lane; ack_o && !we_i |-> dat_o[31:8] == 24'h0; endproperty
    property p_main_run;
        (!cpu_on_subclock_o && !deep_stop_i)[*2] |=> main_osc_enable_o;
    endproperty
    property p_deep; deep_stop_i |=> !main_osc_enable_o; endproperty
    // a source change may only follow a subclock edge
    property p_switch; $changed(cpu_on_subclock_o) |-> $past(sub_tick_i);
    endproperty
    property p_sub_gap;
        cpu_on_subclock_o && !sub_tick_i && !deep_stop_i
            ##1 cpu_on_subclock_o |-> !cpu_clk_en_o;
    endproperty
    property p_fb_set;
        osc_stab_i && wdt_overflow_i |=> internal_osc_fallback_o;
    endproperty
    property p_fb_hold; internal_osc_fallback_o
        |=> internal_osc_fallback_o && internal_osc_enable_o; endproperty
    a_ack_lat: assert property (p_ack_lat)
        else $error("ack missing one cycle after request");
    a_ack_one: assert property (p_ack_one)
        else $error("ack held longer than one cycle");
    a_rd_lane: assert property (p_rd_lane)
        else $error("upper read data lanes not zero");
    a_main_run: assert property (p_main_run)
        else $error("main oscillator stopped while cpu on main clock");
    a_deep: assert property (p_deep)
        else $error("main oscillator runs in deep stop");
    a_switch: assert property (p_switch)
        else $error("clock source changed without subclock edge");
    a_sub_gap: assert property (p_sub_gap)
        else $error("cpu clock enable on subclock without tick");
    a_fb_set: assert property (p_fb_set)
        else $error("fallback flag not set on overflow");
    a_fb_hold: assert property (p_fb_hold)
        else $error("fallback lost or internal oscillator stopped");
    c_write: cover property (ack_o && we_i);
    c_sub: cover property ($rose(cpu_on_subclock_o));
    c_fb: cover property ($rose(internal_osc_fallback_o));
endmodule
bind cscc_top cscc_checker u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .dat_o(dat_o), .ack_o(ack_o), .sub_tick_i(sub_tick_i),
    .osc_stab_i(osc_stab_i), .wdt_overflow_i(wdt_overflow_i),
    .deep_stop_i(deep_stop_i), .cpu_clk_en_o(cpu_clk_en_o),
    .cpu_on_subclock_o(cpu_on_subclock_o),
    .main_osc_enable_o(main_osc_enable_o),
    .main_feedback_resistor_off_o(main_feedback_resistor_off_o),
    .sub_feedback_resistor_off_o(sub_feedback_resistor_off_o),
    .internal_osc_enable_o(internal_osc_enable_o),
    .internal_osc_fallback_o(internal_osc_fallback_o));
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the cpu clock select control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [31:0] A_CTRL = cscc_pkg::ADDR_PROCESSOR_CLOCK_CONTROL;
    localparam logic [31:0] A_MODE = cscc_pkg::ADDR_INTERNAL_OSC_MODE;
    localparam logic [31:0] A_STAT = cscc_pkg::ADDR_CPU_CLOCK_SOURCE_STATUS;
    localparam logic [31:0] A_PROT = cscc_pkg::ADDR_PROTECTION_COMMAND;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [31:0] adr_i = 32'h0;
    logic [31:0] dat_i = 32'h0;
    logic [3:0]  sel_i = 4'h0;
    logic        we_i = 1'b0;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        sub_tick_i = 1'b0;
    logic        osc_stab_i = 1'b0;
    logic        wdt_overflow_i = 1'b0;
    logic        deep_stop_i = 1'b0;
    logic [31:0] dat_o;
    logic        ack_o, cpu_clk_en_o, cpu_on_subclock_o, main_osc_enable_o;
    logic        main_fb_off, sub_fb_off, int_osc_en, int_fallback;
    logic [31:0] rv;
    int          n_fail = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          sub_cnt = 0;

    cscc_top dut (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .dat_o(dat_o), .ack_o(ack_o), .sub_tick_i(sub_tick_i),
        .osc_stab_i(osc_stab_i), .wdt_overflow_i(wdt_overflow_i),
        .deep_stop_i(deep_stop_i), .cpu_clk_en_o(cpu_clk_en_o),
        .cpu_on_subclock_o(cpu_on_subclock_o),
        .main_osc_enable_o(main_osc_enable_o),
        .main_feedback_resistor_off_o(main_fb_off),
        .sub_feedback_resistor_off_o(sub_fb_off),
        .internal_osc_enable_o(int_osc_en),
        .internal_osc_fallback_o(int_fallback));

    always #2 clk_i = ~clk_i;
    // ----------------------------------------------------------------
    // subclock edges and run limit
    // ----------------------------------------------------------------
    // period 40 keeps divide-by-8 main clock above four subclocks
    always @(posedge clk_i) begin
        sub_cnt <= (sub_cnt == 39) ? 0 : sub_cnt + 1;
        sub_tick_i <= (sub_cnt == 39);
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_fail++;
            complete_run;
        end
    end
    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic [31:0] a, input logic w,
                      input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        adr_i <= a;
        we_i <= w;
        dat_i <= d;
        sel_i <= s;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rv = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        wb(a, 1'b1, {24'h0, d}, 4'h1);
    endtask
    task automatic rd(input string nm, input logic [31:0] a,
                      input logic [7:0] e);
        wb(a, 1'b0, 32'h0, 4'h1);
        chk(nm, {24'h0, e}, rv);
    endtask
    task automatic pwr(input logic [7:0] d);
        wr(A_PROT, 8'h00);
        wr(A_CTRL, d);
    endtask
    // skips two pulses so a ratio change has settled
    task automatic per(input string nm, input int e);
        int n;
        n = 0;
        do @(posedge clk_i); while (cpu_clk_en_o !== 1'b1);
        do @(posedge clk_i); while (cpu_clk_en_o !== 1'b1);
        do begin
            @(posedge clk_i);
            n++;
        end while (cpu_clk_en_o !== 1'b1);
        chk(nm, e, n);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("ctrl reset", A_CTRL, 8'h03);
        rd("mode reset", A_MODE, 8'h00);
        rd("stat reset", A_STAT, 8'h00);
        $display("test reset done");
        wr(A_CTRL, 8'hE0);
        rd("ctrl unprotected", A_CTRL, 8'h03);
        wr(A_PROT, 8'h00);
        rd("mode between", A_MODE, 8'h00);
        wr(A_CTRL, 8'hE0);
        rd("ctrl disarmed", A_CTRL, 8'h03);
        wb(A_MODE, 1'b1, 32'h1, 4'hE);
        rd("mode lane off", A_MODE, 8'h00);
        rd("unmapped", 32'hFFFFF900, 8'h00);
        $display("test protection done");
        pwr(8'hA3);
        rd("ctrl resistors", A_CTRL, 8'hA3);
        chk("sub resistor off", 32'h1, sub_fb_off);
        chk("main resistor off", 32'h1, main_fb_off);
        pwr(8'h13);
        rd("ctrl status bit", A_CTRL, 8'h03);
        for (int i = 0; i < 6; i++) begin
            pwr(8'(i));
            per("divider period", 1 << i);
        end
        pwr(8'h06);
        rd("ctrl prohibited", A_CTRL, 8'h06);
        per("prohibited ratio", 32);
        pwr(8'h03);
        per("divide by 8", 8);
        $display("test divider done");
        pwr(8'h4B);
        chk("main osc on main", 32'h1, main_osc_enable_o);
        repeat (42) @(posedge clk_i);
        chk("on subclock", 32'h1, cpu_on_subclock_o);
        chk("main osc stopped", 32'h0, main_osc_enable_o);
        rd("ctrl on sub", A_CTRL, 8'h5B);
        per("subclock period", 40);
        pwr(8'h0B);
        repeat (50) @(posedge clk_i);
        chk("main osc restart", 32'h1, main_osc_enable_o);
        pwr(8'h03);
        repeat (42) @(posedge clk_i);
        chk("back on main", 32'h0, cpu_on_subclock_o);
        per("main again", 8);
        $display("test switch done");
        deep_stop_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("deep stop", 32'h0, main_osc_enable_o);
        deep_stop_i <= 1'b0;
        wr(A_MODE, 8'h01);
        repeat (2) @(posedge clk_i);
        chk("int osc stopped", 32'h0, int_osc_en);
        osc_stab_i <= 1'b1;
        wdt_overflow_i <= 1'b1;
        @(posedge clk_i);
        wdt_overflow_i <= 1'b0;
        osc_stab_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("fallback", 32'h1, int_fallback);
        chk("int osc kept", 32'h1, int_osc_en);
        rd("mode stays", A_MODE, 8'h01);
        wr(A_STAT, 8'h00);
        rd("stat fallback", A_STAT, 8'h01);
        $display("test internal osc done");
        complete_run;
    end
endmodule
`default_nettype wire
